// ---- testbench/ics_link_properties.sv ----
// Concurrent checks on the cyclic link between the two ends.
// Assumes it sits beside the link interface and sees its signals as inputs.
`timescale 1ns/1ps
module ics_link_properties
  import ics_pkg::*;
(
  input wire logic pclk,              // System clock
  input wire logic presetn,           // Reset, active low
  input wire logic in_valid,          // Frame strobe
  input wire logic [1:0] in_slot,     // Frame slot
  input wire logic [15:0] in_weight,  // Frame weight
  input wire logic [15:0] in_status,  // Frame status, wire order
  input wire logic cmd_valid,         // Command strobe
  input wire logic [15:0] cmd_code,   // Command code
  input wire logic [15:0] cmd_data    // Command data
);
  // ==========================================
  // Slot 0 scale-valid flag as last seen on the wire
  logic ok0_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ok0_r <= 1'b0;
    end else if (in_valid && in_slot == 2'd0) begin
      ok0_r <= in_status[ICS_ST_DATA_OK - 8];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================
  // Properties
  sequence s_preset_sent;
    cmd_valid && cmd_code == ICS_CMD_PRESET_TARE;
  endsequence
  sequence s_plain_sent;
    cmd_valid && cmd_code != ICS_CMD_PRESET_TARE;
  endsequence
  property p_slot_hold;
    !in_valid |-> $stable(in_slot);
  endproperty
  property p_frame_hold;
    !in_valid |-> $stable({in_weight, in_status});
  endproperty
  property p_code_legal;
    cmd_valid |-> cmd_code inside {[ICS_CMD_TARE:ICS_CMD_NET]};
  endproperty
  property p_cmd_hold;
    !cmd_valid |-> $stable({cmd_code, cmd_data});
  endproperty
  property p_cmd_gate;
    s_plain_sent |-> $past(ok0_r);
  endproperty
  property p_plain_data;
    s_plain_sent |-> cmd_data == 16'h0000;
  endproperty
  property p_preset_spacing;
    s_preset_sent |=> (!(cmd_valid && cmd_code == ICS_CMD_PRESET_TARE)) [*8];
  endproperty
  property p_no_repeat;
    cmd_valid |=> !(cmd_valid && $stable(cmd_code));
  endproperty

  a_slot_hold: assert property (p_slot_hold) else $error("slot changed between frames");
  a_frame_hold: assert property (p_frame_hold) else $error("frame data changed between frames");
  a_code_legal: assert property (p_code_legal) else $error("illegal command code");
  a_cmd_hold: assert property (p_cmd_hold) else $error("command changed without strobe");
  a_cmd_gate: assert property (p_cmd_gate) else $error("command while scale not valid");
  a_plain_data: assert property (p_plain_data) else $error("data on a plain command");
  a_preset_spacing: assert property (p_preset_spacing) else $error("preset sent without divide");
  a_no_repeat: assert property (p_no_repeat) else $error("command repeated");
  c_preset: cover property (s_preset_sent);
endmodule

// ---- testbench/integer_cyclic_scale_exchange_bench.sv ----
// Self-checking bench joining both ends across the link interface.
// Assumes the design files of verilog/ are compiled first.
`timescale 1ns/1ps
module integer_cyclic_scale_exchange_bench
  import ics_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, term_send, term_cmd_strobe;
  logic [7:0] paddr, term_low_flags, hi_flags, hi, lo;
  logic [31:0] pwdata, prdata, scale, outd, lfsr_state;
  logic [15:0] term_weight, term_cmd_code, term_cmd_data, w;
  logic [1:0] term_slot;
  logic [31:0] slot_w [4];
  logic [32:0] exp_rd [$];
  logic [31:0] exp_cmd [$];
  int num_errors = 0;
  int samples_checked = 0;

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  ics_link_if link (.pclk(pclk), .presetn(presetn));
  ics_term_end i_ics_term_end (.link(link.term), .term_send(term_send), .term_slot(term_slot),
    .term_weight(term_weight), .term_low_flags(term_low_flags), .term_enter(hi_flags[0]),
    .term_inputs(hi_flags[3:1]), .term_motion(hi_flags[4]), .term_net(hi_flags[5]),
    .term_updating(hi_flags[6]), .term_data_ok(hi_flags[7]), .term_cmd_strobe(term_cmd_strobe),
    .term_cmd_code(term_cmd_code), .term_cmd_data(term_cmd_data));
  ics_ctrl_end i_ics_ctrl_end (.link(link.ctrl), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  ics_link_properties i_ics_link_properties (.pclk(pclk), .presetn(presetn), .in_valid(link.in_valid),
    .in_slot(link.in_slot), .in_weight(link.in_weight), .in_status(link.in_status),
    .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code), .cmd_data(link.cmd_data));

  // ==========================================
  // Helpers
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction

  task automatic cmp(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Reads note {pslverr, prdata} before the transfer; the monitor compares
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data, input logic [32:0] exp);
    if (!wr) exp_rd.push_back(exp);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic frame(input logic [1:0] slot, input logic [15:0] wt, input logic [7:0] h, input logic [7:0] l);
    @(posedge pclk);
    term_send <= 1'b1;
    term_slot <= slot;
    term_weight <= wt;
    hi_flags <= h;
    term_low_flags <= l;
    @(posedge pclk);
    term_send <= 1'b0;
    @(negedge pclk);
    cmp({link.in_valid, link.in_slot, link.in_weight, link.in_status}, {1'b1, slot, wt, l, h});
    repeat (2) @(posedge pclk);
  endtask

  // ==========================================
  // Result monitor
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      cmp({pslverr, prdata}, exp_rd.size() ? exp_rd.pop_front() : ~{pslverr, prdata});
    end
    if (term_cmd_strobe === 1'b1) begin
      cmp({term_cmd_code, term_cmd_data}, exp_cmd.size() ? exp_cmd.pop_front() : ~{term_cmd_code, term_cmd_data});
    end
  end

  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    print_verdict();
  end

  // ==========================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    term_send = 1'b0;
    term_slot = 2'h0;
    term_weight = 16'h0;
    term_low_flags = 8'h00;
    hi_flags = 8'h00;
    lfsr_state = 32'h9a64a3f4;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ICS_OFS_SCALE, 32'h0, {1'b0, ICS_RST_SCALE});
    apb(1'b0, ICS_OFS_STATE, 32'h0, 33'h0);
    frame(2'd0, 16'h0123, 8'h80, 8'h00);
    apb(1'b0, ICS_OFS_IRQ_STAT, 32'h0, 33'h0);
    apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
    apb(1'b1, ICS_OFS_CTRL, 32'h1, 33'h0);
    apb(1'b0, ICS_OFS_STATE, 32'h0, 33'h1);
    lfsr_state = next_rand(lfsr_state);
    scale = {12'h000, lfsr_state[19:0]} | 32'h1;
    apb(1'b1, ICS_OFS_SCALE, scale, 33'h0);
    for (int s = 0; s < 4; s++) begin
      lfsr_state = next_rand(lfsr_state);
      hi = {2'b10, lfsr_state[29:24]};
      lo = lfsr_state[23:16];
      w = lfsr_state[15:0];
      slot_w[s] = {{16{w[15]}}, w} * scale;
      frame(2'(s), w, hi, lo);
      apb(1'b0, ICS_OFS_WEIGHT0 + 8'(4 * s), 32'h0, {1'b0, slot_w[s]});
      apb(1'b0, ICS_OFS_STATUS0 + 8'(4 * s), 32'h0, {17'h0, hi, lo});
    end
    // Refresh pending keeps the old weight, but the status is stored
    frame(2'd1, ~w, 8'hc0, 8'h00);
    apb(1'b0, ICS_OFS_WEIGHT0 + 8'h4, 32'h0, {1'b0, slot_w[1]});
    apb(1'b0, ICS_OFS_STATUS0 + 8'h4, 32'h0, {17'h0, 16'hc000});
    frame(2'd2, w, 8'h00, 8'h00);
    apb(1'b0, ICS_OFS_WEIGHT0 + 8'h8, 32'h0, {1'b0, ICS_BAD_DATA});
    apb(1'b0, ICS_OFS_IRQ_STAT, 32'h0, 33'h3);
    cmp(irq, 1'b0);
    apb(1'b1, ICS_OFS_IRQ_MASK, 32'h2, 33'h0);
    @(negedge pclk);
    cmp(irq, 1'b1);
    apb(1'b1, ICS_OFS_IRQ_STAT, 32'h2, 33'h0);
    @(negedge pclk);
    cmp(irq, 1'b0);
    // Trigger held while slot 0 reports bad data, sent once data is fine
    frame(2'd0, w, 8'h00, 8'h00);
    apb(1'b1, ICS_OFS_TRIG, 32'h1, 33'h0);
    repeat (6) @(posedge pclk);
    apb(1'b0, ICS_OFS_TRIG, 32'h0, 33'h1);
    exp_cmd.push_back({ICS_CMD_TARE, 16'h0});
    frame(2'd0, w, 8'h80, 8'h00);
    repeat (6) @(posedge pclk);
    apb(1'b0, ICS_OFS_TRIG, 32'h0, 33'h0);
    for (int i = 1; i < ICS_TRIG_BITS; i++) begin
      if (i != ICS_TRIG_PRESET) begin
        exp_cmd.push_back({16'(i + 1), 16'h0});
        apb(1'b1, ICS_OFS_TRIG, 32'h1 << i, 33'h0);
        repeat (5) @(posedge pclk);
      end
    end
    // Two triggers at once go out lowest first, back to back
    exp_cmd.push_back({ICS_CMD_TARE, 16'h0});
    exp_cmd.push_back({ICS_CMD_CLEAR, 16'h0});
    apb(1'b1, ICS_OFS_TRIG, 32'h3, 33'h0);
    repeat (6) @(posedge pclk);
    lfsr_state = next_rand(lfsr_state);
    outd = {{12{lfsr_state[19]}}, lfsr_state[19:0]};
    exp_cmd.push_back({ICS_CMD_PRESET_TARE, 16'($signed(outd) / $signed(scale))});
    apb(1'b1, ICS_OFS_OUTDATA, outd, 33'h0);
    apb(1'b1, ICS_OFS_TRIG, 32'h1 << ICS_TRIG_PRESET, 33'h0);
    repeat (45) @(posedge pclk);
    cmp(exp_rd.size(), 0);
    cmp(exp_cmd.size(), 0);
    print_verdict();
  end
endmodule

// ---- verilog/ics_ctrl_end.sv ----
// Controller end: filters and scales cyclic weights, issues commands.
// Assumes an APB master on pclk and the terminal end on the same clock.
//
// Notes on behaviour
// [R1] Swap status bytes before reading any flag
// [R2] Accept weight only when valid, not updating
// [R3] Sign-extend integer weight before conversion
// [R4] Multiply by increment scale, store in slot
// [R5] Store bad-data marker when scale not valid
// [R6] Issue triggered commands only while scale valid
// [R7] Clear trigger bit once its command issued
// [R8] Divide outgoing value by increment to integer
// [R9] Four six-byte slots, fewer allowed
// [R10] Status bit 8 flags enter key
// [R11] Status bits 9 to 11 mirror inputs
// [R12] Status bits 12, 13: motion, net mode
// [R13] Status bit 14: updating, ignore data
// [R14] Status bit 15: scale valid for operation
// [R15] Load starting values before any cyclic processing
// [R16] Discarded weight keeps previous stored value
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
module ics_ctrl_end
  import ics_pkg::*;
(
  ics_link_if.ctrl link,           // Link to the terminal
  input wire logic psel,           // APB select
  input wire logic penable,        // APB access phase
  input wire logic pwrite,         // APB write
  input wire logic [7:0] paddr,    // APB byte address
  input wire logic [31:0] pwdata,  // APB write data
  output logic [31:0] prdata,      // APB read data
  output logic pready,             // APB ready, always high
  output logic pslverr,            // APB error on unmapped address
  output logic irq                 // Level interrupt
);
  ics_state_t state_r;
  logic enable_r;
  logic [31:0] scale_r;
  logic [ICS_TRIG_BITS-1:0] trig_r;
  logic [31:0] outdata_r;
  logic [ICS_IRQ_BITS-1:0] irq_stat_r;
  logic [ICS_IRQ_BITS-1:0] irq_mask_r;
  logic [31:0] weight_r [ICS_SLOTS];
  logic [15:0] status_r [ICS_SLOTS];
  logic scale_ok_r;
  logic [31:0] rem_r;
  logic [31:0] quo_r;
  logic [4:0] div_cnt_r;
  logic div_neg_r;

  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [15:0] rx_status;
  logic rx_ok;
  logic rx_upd;
  logic [31:0] rx_wide;
  logic [47:0] rx_prod;
  logic issue;
  logic [2:0] issue_idx;
  logic [15:0] issue_code;
  logic [ICS_TRIG_BITS-1:0] trig_clr;
  logic [ICS_IRQ_BITS-1:0] irq_set;
  logic [32:0] div_trial;
  logic [31:0] div_abs_b;
  logic [15:0] div_q;

  // ==========================================
  // APB decode; zero wait states
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  always_comb begin
    prdata = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      ICS_OFS_CTRL: prdata = {31'h0, enable_r};
      ICS_OFS_SCALE: prdata = scale_r;
      ICS_OFS_TRIG: prdata = {26'h0, trig_r};
      ICS_OFS_OUTDATA: prdata = outdata_r;
      ICS_OFS_IRQ_STAT: prdata = {29'h0, irq_stat_r};
      ICS_OFS_IRQ_MASK: prdata = {29'h0, irq_mask_r};
      ICS_OFS_STATE: prdata = {29'h0, scale_ok_r, state_r};
      default: begin
        if (paddr[7:4] == ICS_OFS_WEIGHT0[7:4] && paddr[1:0] == 2'h0) begin
          prdata = weight_r[paddr[3:2]];  // [R9]
        end else if (paddr[7:4] == ICS_OFS_STATUS0[7:4] && paddr[1:0] == 2'h0) begin
          prdata = {16'h0, status_r[paddr[3:2]]};
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  // ==========================================
  // Received frame: exchange bytes, then read flags
  assign rx_status = {link.in_status[7:0], link.in_status[15:8]};  // [R1]
  assign rx_ok = rx_status[ICS_ST_DATA_OK];
  assign rx_upd = rx_status[ICS_ST_UPDATING];
  assign rx_wide = {{16{link.in_weight[15]}}, link.in_weight};  // [R3]
  // Integer times Q16.16 increment; wrap above 32767 units is accepted
  assign rx_prod = 48'($signed(rx_wide) * $signed({{16{scale_r[31]}}, scale_r}));  // [R4]

  // ==========================================
  // Start-up: settings loaded before cyclic processing begins
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      state_r <= ICS_INIT;
    end else begin
      case (state_r)
        ICS_INIT: if (enable_r) state_r <= ICS_RUN;  // [R15]
        ICS_RUN: if (issue && issue_idx == 3'(ICS_TRIG_PRESET)) state_r <= ICS_DIVIDE;
        ICS_DIVIDE: if (div_cnt_r == 5'(ICS_DIV_STEPS - 1)) state_r <= ICS_RUN;
        default: state_r <= ICS_INIT;
      endcase
    end
  end

  // ==========================================
  // Settings
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      enable_r <= 1'b0;
      scale_r <= ICS_RST_SCALE;  // [R15]
      outdata_r <= 32'h0000_0000;
      irq_mask_r <= '0;
    end else if (wr_en) begin
      if (paddr == ICS_OFS_CTRL) enable_r <= pwdata[0];
      if (paddr == ICS_OFS_SCALE) scale_r <= pwdata;
      if (paddr == ICS_OFS_OUTDATA) outdata_r <= pwdata;
      if (paddr == ICS_OFS_IRQ_MASK) irq_mask_r <= pwdata[ICS_IRQ_BITS-1:0];
    end
  end

  // ==========================================
  // Slot storage
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      for (int i = 0; i < ICS_SLOTS; i++) begin
        weight_r[i] <= 32'h0000_0000;
        status_r[i] <= 16'h0000;
      end
      scale_ok_r <= 1'b0;
    end else if (link.in_valid && state_r != ICS_INIT) begin
      status_r[link.in_slot] <= rx_status;  // [R1]
      if (link.in_slot == 2'h0) scale_ok_r <= rx_ok;
      if (!rx_ok) begin
        weight_r[link.in_slot] <= ICS_BAD_DATA;  // [R5]
      end else if (!rx_upd) begin
        weight_r[link.in_slot] <= rx_prod[31:0];  // [R2] [R4]
      end
      // Valid but updating: the stored weight stands [R16]
    end
  end

  // ==========================================
  // Commands: lowest pending trigger first, slot 0's flag gates them
  always_comb begin
    issue_idx = 3'h0;
    for (int i = ICS_TRIG_BITS - 1; i >= 0; i--) begin
      if (trig_r[i]) issue_idx = 3'(i);
    end
  end
  assign issue = state_r == ICS_RUN && scale_ok_r && |trig_r;  // [R6]

  always_comb begin
    case (issue_idx)
      3'h0: issue_code = ICS_CMD_TARE;
      3'h1: issue_code = ICS_CMD_CLEAR;
      3'h2: issue_code = ICS_CMD_ZERO;
      3'h3: issue_code = ICS_CMD_PRESET_TARE;
      3'h4: issue_code = ICS_CMD_GROSS;
      3'h5: issue_code = ICS_CMD_NET;
      default: issue_code = ICS_CMD_NONE;
    endcase
  end

  always_comb begin
    trig_clr = '0;
    if (issue) trig_clr[issue_idx] = 1'b1;  // [R7]
  end

  // A write that sets a trigger in the cycle it is cleared wins
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      trig_r <= '0;
    end else begin
      trig_r <= (trig_r & ~trig_clr) |
                ((wr_en && paddr == ICS_OFS_TRIG) ? pwdata[ICS_TRIG_BITS-1:0] : '0);  // [R7]
    end
  end

  // ==========================================
  // Outgoing data: restoring divide of |outdata| by |scale|
  assign div_abs_b = scale_r[31] ? 32'(-scale_r) : scale_r;
  assign div_trial = {rem_r, quo_r[31]} - {1'b0, div_abs_b};
  // The last quotient bit is decided in the cycle that sends the command, so take it from the trial here
  assign div_q = div_neg_r ? 16'(-{quo_r[30:0], !div_trial[32]}) : {quo_r[14:0], !div_trial[32]};

  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      rem_r <= 32'h0000_0000;
      quo_r <= 32'h0000_0000;
      div_cnt_r <= 5'h00;
      div_neg_r <= 1'b0;
    end else if (state_r == ICS_RUN) begin
      rem_r <= 32'h0000_0000;
      quo_r <= outdata_r[31] ? 32'(-outdata_r) : outdata_r;
      div_neg_r <= outdata_r[31] ^ scale_r[31];
      div_cnt_r <= 5'h00;
    end else if (state_r == ICS_DIVIDE) begin
      div_cnt_r <= div_cnt_r + 5'h01;
      if (!div_trial[32]) begin
        rem_r <= div_trial[31:0];
        quo_r <= {quo_r[30:0], 1'b1};  // [R8]
      end else begin
        rem_r <= {rem_r[30:0], quo_r[31]};
        quo_r <= {quo_r[30:0], 1'b0};
      end
    end
  end

  // ==========================================
  // Command output; preset tare waits for the quotient
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      link.cmd_valid <= 1'b0;
      link.cmd_code <= ICS_CMD_NONE;
      link.cmd_data <= 16'h0000;
    end else begin
      link.cmd_valid <= 1'b0;
      if (issue && issue_idx != 3'(ICS_TRIG_PRESET)) begin
        link.cmd_valid <= 1'b1;  // [R6]
        link.cmd_code <= issue_code;
        link.cmd_data <= 16'h0000;
      end else if (state_r == ICS_DIVIDE && div_cnt_r == 5'(ICS_DIV_STEPS)) begin
        link.cmd_valid <= 1'b0;
      end else if (state_r == ICS_RUN && link.cmd_code == ICS_CMD_NONE) begin
        link.cmd_valid <= 1'b0;
      end
      if (state_r == ICS_DIVIDE && div_cnt_r == 5'(ICS_DIV_STEPS - 1)) begin
        link.cmd_valid <= 1'b1;
        link.cmd_code <= ICS_CMD_PRESET_TARE;
        link.cmd_data <= div_q;  // [R8]
      end
    end
  end

  // ==========================================
  // Interrupts: set wins over write-one-to-clear
  always_comb begin
    irq_set = '0;
    irq_set[ICS_IRQ_ACCEPT] = link.in_valid && state_r != ICS_INIT && rx_ok && !rx_upd;
    irq_set[ICS_IRQ_BAD] = link.in_valid && state_r != ICS_INIT && !rx_ok;
    irq_set[ICS_IRQ_CMD] = link.cmd_valid;
  end

  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r &
                     ~((wr_en && paddr == ICS_OFS_IRQ_STAT) ? pwdata[ICS_IRQ_BITS-1:0] : '0)) | irq_set;
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  logic unused_rd;
  assign unused_rd = rd_en;
endmodule

// ---- verilog/ics_link_if.sv ----
// Cyclic link between the weighing terminal end and the controller end.
// Assumes both ends sit on pclk; the bench instantiates and joins them.
`timescale 1ns/1ps
interface ics_link_if (
  input logic pclk,    // System clock
  input logic presetn  // Asynchronous reset, active low
);
  logic in_valid;       // Terminal to controller: frame strobe
  logic [1:0] in_slot;  // Message slot of the frame
  logic [15:0] in_weight;  // Signed integer weight
  logic [15:0] in_status;  // Status word, bytes in wire order
  logic cmd_valid;      // Controller to terminal: command strobe
  logic [15:0] cmd_code;   // Command code
  logic [15:0] cmd_data;   // Integer data with the command

  modport term (
    input pclk, presetn, cmd_valid, cmd_code, cmd_data,
    output in_valid, in_slot, in_weight, in_status
  );
  modport ctrl (
    input pclk, presetn, in_valid, in_slot, in_weight, in_status,
    output cmd_valid, cmd_code, cmd_data
  );
endinterface

// ---- verilog/ics_pkg.sv ----
// Shared constants for the integer cyclic scale exchange.
// Assumes one clock, pclk, shared by both ends and the APB master.
package ics_pkg;

  // ==========================================
  // Link layout
  localparam int ICS_SLOTS = 4;
  localparam int ICS_SLOT_BYTES = 6;
  localparam int ICS_W_BITS = 16;
  // Status word bit positions after the byte exchange (second byte on top)
  localparam int ICS_ST_ENTER = 8;
  localparam int ICS_ST_IN1 = 9;
  localparam int ICS_ST_MOTION = 12;
  localparam int ICS_ST_NET = 13;
  localparam int ICS_ST_UPDATING = 14;
  localparam int ICS_ST_DATA_OK = 15;

  // ==========================================
  // Command codes, arbitrary encodings
  localparam logic [15:0] ICS_CMD_NONE = 16'h0000;
  localparam logic [15:0] ICS_CMD_TARE = 16'h0001;
  localparam logic [15:0] ICS_CMD_CLEAR = 16'h0002;
  localparam logic [15:0] ICS_CMD_ZERO = 16'h0003;
  localparam logic [15:0] ICS_CMD_PRESET_TARE = 16'h0004;
  localparam logic [15:0] ICS_CMD_GROSS = 16'h0005;
  localparam logic [15:0] ICS_CMD_NET = 16'h0006;
  localparam int ICS_TRIG_BITS = 6;
  localparam int ICS_TRIG_PRESET = 3;

  // ==========================================
  // Controller register map (APB byte addresses)
  localparam logic [7:0] ICS_OFS_CTRL = 8'h00;
  localparam logic [7:0] ICS_OFS_SCALE = 8'h04;
  localparam logic [7:0] ICS_OFS_TRIG = 8'h08;
  localparam logic [7:0] ICS_OFS_OUTDATA = 8'h0c;
  localparam logic [7:0] ICS_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] ICS_OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] ICS_OFS_STATE = 8'h18;
  localparam logic [7:0] ICS_OFS_WEIGHT0 = 8'h20;
  localparam logic [7:0] ICS_OFS_STATUS0 = 8'h30;

  // Reset values; weights are signed Q16.16 fixed point
  localparam logic [31:0] ICS_RST_SCALE = 32'h0000_0041;
  localparam logic [31:0] ICS_BAD_DATA = 32'h8000_0000;
  localparam int ICS_FRAC_BITS = 16;
  localparam int ICS_DIV_STEPS = 32;

  // Interrupt status bits
  localparam int ICS_IRQ_ACCEPT = 0;
  localparam int ICS_IRQ_BAD = 1;
  localparam int ICS_IRQ_CMD = 2;
  localparam int ICS_IRQ_BITS = 3;

  typedef enum logic [1:0] {
    ICS_INIT = 2'b00,
    ICS_RUN = 2'b01,
    ICS_DIVIDE = 2'b11
  } ics_state_t;

endpackage

// ---- verilog/ics_term_end.sv ----
// Weighing terminal end: packs weight and status flags into a cyclic frame.
// Assumes the user side gives synchronous levels and a one-cycle send strobe.
`timescale 1ns/1ps
module ics_term_end
  import ics_pkg::*;
(
  ics_link_if.term link,          // Link to the controller
  input wire logic term_send,     // Pulse: emit one frame
  input wire logic [1:0] term_slot,  // Slot of the frame
  input wire logic [15:0] term_weight,  // Signed integer weight
  input wire logic [7:0] term_low_flags,  // Target and comparator flags
  input wire logic term_enter,    // Enter key press detected
  input wire logic [2:0] term_inputs,  // Discrete inputs one to three
  input wire logic term_motion,   // Scale in motion
  input wire logic term_net,      // Net weighing mode
  input wire logic term_updating, // Data update in progress
  input wire logic term_data_ok,  // Scale fit for normal operation
  output logic term_cmd_strobe,   // Pulse: command received
  output logic [15:0] term_cmd_code,  // Last command code
  output logic [15:0] term_cmd_data   // Last command data
);
  logic [15:0] status_nxt;

  // ==========================================
  // Status word, second byte on top
  always_comb begin
    status_nxt = {8'h00, term_low_flags};
    status_nxt[ICS_ST_ENTER] = term_enter;  // [R10]
    status_nxt[ICS_ST_IN1 +: 3] = term_inputs;  // [R11]
    status_nxt[ICS_ST_MOTION] = term_motion;  // [R12]
    status_nxt[ICS_ST_NET] = term_net;  // [R12]
    status_nxt[ICS_ST_UPDATING] = term_updating;  // [R13]
    status_nxt[ICS_ST_DATA_OK] = term_data_ok;  // [R14]
  end

  // ==========================================
  // Frame out; the wire carries the status bytes exchanged
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      link.in_valid <= 1'b0;
      link.in_slot <= 2'h0;
      link.in_weight <= 16'h0000;
      link.in_status <= 16'h0000;
    end else begin
      link.in_valid <= term_send;
      if (term_send) begin
        link.in_slot <= term_slot;
        link.in_weight <= term_weight;
        link.in_status <= {status_nxt[7:0], status_nxt[15:8]};
      end
    end
  end

  // ==========================================
  // Command in
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      term_cmd_strobe <= 1'b0;
      term_cmd_code <= 16'h0000;
      term_cmd_data <= 16'h0000;
    end else begin
      term_cmd_strobe <= link.cmd_valid;
      if (link.cmd_valid) begin
        term_cmd_code <= link.cmd_code;
        term_cmd_data <= link.cmd_data;
      end
    end
  end
endmodule
